/* File: rtl/dcrb_cmd_bank.v */
// Purpose: link-writable command words of a motor drive, with source
//   precedence, clamping and alarm reset handling
// Assumes: link access port is on core_clk; link enable pin is async
// Notes:
// How it works
// - nonzero per-unit word beats centihertz word
// - nonzero centihertz word beats speed command
// - per-unit word signed, 20000 is maximum
// - centihertz word unsigned, 0.01 Hz steps
// - pid setpoint signed, 20000 is 100 percent
// - speed word signed rpm, any 16-bit value
// - store above 20000, clamp applied value
// - variant option: negative pid setpoint used as zero
// - reads return last written, not effective value
// - run word bit 15 set-then-clear resets alarm
// - run word reset needs link made valid
// - writing one to clear word pulses reset
// - clear word reads zero, accepts zero or one
// - clear word works regardless of link validity
// - general bits follow their terminal assignment
// - forward, reverse, reset bits come from link only
// - codes 0-3 are weighted step select bits
// - codes 4 and 5 pick ramp time sets
// - code 7 commands coast to stop
// - run word is 16 bits, any value
// - link commands are always positive logic
`timescale 1ns/100ps
`include "dcrb_defines.vh"

module dcrb_cmd_bank #(
  parameter NGP = 11,
  parameter PID_NEG_ZERO = 0,
  parameter [19:0] RST_PULSE_CYC = `DCRB_RST_PULSE_CYC
) (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  // link access port
  input wire wr_en,
  input wire rd_en,
  input wire [`DCRB_IDX_W-1:0] word_idx,
  input wire [15:0] wr_data,
  output reg [15:0] rd_data_ff,
  output reg rd_valid_ff,
  // link source configuration
  input wire link_source_select,
  input wire bus_source_select,
  input wire loader_source_select,
  input wire link_enable_assigned,
  input wire link_enable_input,
  input wire [NGP*8-1:0] terminal_assign_setting,
  input wire [15:0] upper_limit_pu,
  // commands to the drive control
  output reg [1:0] freq_src_ff,
  output reg [15:0] freq_ref_ff,
  output reg [15:0] pid_setpoint_ff,
  output reg [15:0] speed_ff,
  output reg forward_run_ff,
  output reg reverse_run_ff,
  output reg [3:0] step_select_ff,
  output reg [1:0] ramp_set_sel_ff,
  output reg coast_stop_ff,
  output reg fault_reset_ff,
  output reg link_valid_ff
);

  // stored words, as last written
  reg [15:0] freq_ref_per_unit_ff;
  reg [15:0] freq_ref_centihertz_ff;
  reg [15:0] pid_setpoint_word_ff;
  reg [15:0] speed_command_rpm_ff;
  reg [15:0] run_command_word_ff;
  reg [3:0] written_ff;
  reg [19:0] rst_cnt_ff;
  reg le_meta_ff;
  reg le_sync_ff;

  reg [19:0] nxt_rst_cnt;
  reg [1:0] nxt_src;
  reg [15:0] nxt_freq;
  reg [15:0] pu_lim;
  reg [3:0] nxt_step;
  reg [1:0] nxt_ramp;
  reg nxt_coast;
  reg [7:0] asg;
  reg [15:0] rd_mux;
  integer i;

  wire wr_pu = wr_en && (word_idx == `DCRB_IDX_PU);
  wire wr_chz = wr_en && (word_idx == `DCRB_IDX_CHZ);
  wire wr_pid = wr_en && (word_idx == `DCRB_IDX_PID);
  wire wr_rpm = wr_en && (word_idx == `DCRB_IDX_RPM);
  wire wr_run = wr_en && (word_idx == `DCRB_IDX_RUN);
  wire wr_clr = wr_en && (word_idx == `DCRB_IDX_CLR);

  // link is command source only when every setting grants it and the
  // enable terminal, if one is assigned, is on
  wire link_ok = link_source_select && bus_source_select &&
                 loader_source_select &&
                 (!link_enable_assigned || le_sync_ff);

  // falling edge of bit 15 by a fresh write
  wire run_rst_fall = wr_run && run_command_word_ff[`DCRB_BIT_RST] &&
                      !wr_data[`DCRB_BIT_RST];
  // values above one are refused, word keeps no state
  wire clr_one = wr_clr && (wr_data == `DCRB_CLR_ONE);
  wire rst_trig = clr_one || (run_rst_fall && link_ok);

  // pin is async to core_clk
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      le_meta_ff <= 1'b0;
      le_sync_ff <= 1'b0;
    end else begin
      le_meta_ff <= link_enable_input;
      le_sync_ff <= le_meta_ff;
    end
  end

  // full 16-bit words stored as written, no range check
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      freq_ref_per_unit_ff <= `DCRB_WORD_RST;
      freq_ref_centihertz_ff <= `DCRB_WORD_RST;
      pid_setpoint_word_ff <= `DCRB_WORD_RST;
      speed_command_rpm_ff <= `DCRB_WORD_RST;
      run_command_word_ff <= `DCRB_WORD_RST;
      written_ff <= 4'h0;
    end else begin
      if (wr_pu) begin
        freq_ref_per_unit_ff <= wr_data;
        written_ff[0] <= 1'b1;
      end
      if (wr_chz) begin
        freq_ref_centihertz_ff <= wr_data;
        written_ff[1] <= 1'b1;
      end
      if (wr_pid) begin
        pid_setpoint_word_ff <= wr_data;
      end
      if (wr_rpm) begin
        speed_command_rpm_ff <= wr_data;
        written_ff[3] <= 1'b1;
      end
      if (wr_run) begin
        run_command_word_ff <= wr_data;
        written_ff[2] <= 1'b1;
      end
    end
  end

  // read returns the stored word, never the applied one
  always @* begin
    case (word_idx)
      `DCRB_IDX_PU: rd_mux = freq_ref_per_unit_ff;
      `DCRB_IDX_CHZ: rd_mux = freq_ref_centihertz_ff;
      `DCRB_IDX_PID: rd_mux = pid_setpoint_word_ff;
      `DCRB_IDX_RPM: rd_mux = speed_command_rpm_ff;
      `DCRB_IDX_RUN: rd_mux = run_command_word_ff;
      `DCRB_IDX_CLR: rd_mux = `DCRB_WORD_RST;
      default: rd_mux = `DCRB_WORD_RST;
    endcase
  end

  // frequency source precedence and per-unit clamp
  always @* begin
    pu_lim = (upper_limit_pu < `DCRB_PU_FULL) ? upper_limit_pu :
             `DCRB_PU_FULL;
    nxt_src = `DCRB_SRC_NONE;
    nxt_freq = `DCRB_WORD_RST;
    if (written_ff[0] && (freq_ref_per_unit_ff != 16'h0000)) begin
      nxt_src = `DCRB_SRC_PU;
    end else if (written_ff[1] &&
                 (freq_ref_centihertz_ff != 16'h0000)) begin
      nxt_src = `DCRB_SRC_CHZ;
    end else if (written_ff[3]) begin
      nxt_src = `DCRB_SRC_RPM;
    end else if (written_ff[0]) begin
      nxt_src = `DCRB_SRC_PU;
    end else if (written_ff[1]) begin
      nxt_src = `DCRB_SRC_CHZ;
    end
    case (nxt_src)
      `DCRB_SRC_PU: begin
        if ($signed(freq_ref_per_unit_ff) > $signed(pu_lim)) begin
          nxt_freq = pu_lim;
        end else if ($signed(freq_ref_per_unit_ff) <
                     -$signed(pu_lim)) begin
          nxt_freq = 16'h0000 - pu_lim;
        end else begin
          nxt_freq = freq_ref_per_unit_ff;
        end
      end
      `DCRB_SRC_CHZ: nxt_freq = freq_ref_centihertz_ff;
      `DCRB_SRC_RPM: nxt_freq = speed_command_rpm_ff;
      default: nxt_freq = `DCRB_WORD_RST;
    endcase
  end

  // general bits decoded by their assignment code; bits are taken
  // as written, terminal negative-logic settings never apply here
  always @* begin
    nxt_step = 4'h0;
    nxt_ramp = 2'h0;
    nxt_coast = 1'b0;
    asg = 8'h00;
    for (i = 0; i < NGP; i = i + 1) begin
      asg = terminal_assign_setting[i*8 +: 8];
      if (run_command_word_ff[`DCRB_BIT_GP0 + i]) begin
        case (asg)
          `DCRB_ASG_SS1: nxt_step[0] = 1'b1;
          `DCRB_ASG_SS2: nxt_step[1] = 1'b1;
          `DCRB_ASG_SS4: nxt_step[2] = 1'b1;
          `DCRB_ASG_SS8: nxt_step[3] = 1'b1;
          `DCRB_ASG_RT1: nxt_ramp[0] = 1'b1;
          `DCRB_ASG_RT2: nxt_ramp[1] = 1'b1;
          `DCRB_ASG_BX: nxt_coast = 1'b1;
          default: nxt_coast = nxt_coast;
        endcase
      end
    end
  end

  // a retrigger reloads the full length
  always @* begin
    if (rst_trig) begin
      nxt_rst_cnt = RST_PULSE_CYC;
    end else if (rst_cnt_ff != 20'h00000) begin
      nxt_rst_cnt = rst_cnt_ff - 20'h00001;
    end else begin
      nxt_rst_cnt = rst_cnt_ff;
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_ff <= `DCRB_WORD_RST;
      rd_valid_ff <= 1'b0;
      freq_src_ff <= `DCRB_SRC_NONE;
      freq_ref_ff <= `DCRB_WORD_RST;
      pid_setpoint_ff <= `DCRB_WORD_RST;
      speed_ff <= `DCRB_WORD_RST;
      forward_run_ff <= 1'b0;
      reverse_run_ff <= 1'b0;
      step_select_ff <= 4'h0;
      ramp_set_sel_ff <= 2'h0;
      coast_stop_ff <= 1'b0;
      fault_reset_ff <= 1'b0;
      link_valid_ff <= 1'b0;
      rst_cnt_ff <= 20'h00000;
    end else begin
      rd_valid_ff <= rd_en;
      if (rd_en) begin
        rd_data_ff <= rd_mux;
      end
      freq_src_ff <= nxt_src;
      freq_ref_ff <= nxt_freq;
      if (PID_NEG_ZERO != 0 && pid_setpoint_word_ff[15]) begin
        pid_setpoint_ff <= 16'h0000;
      end else begin
        pid_setpoint_ff <= pid_setpoint_word_ff;
      end
      speed_ff <= speed_command_rpm_ff;
      // run only while the link owns commands; the host must drop
      // these before a reset or the drive restarts at once
      forward_run_ff <= link_ok &&
        run_command_word_ff[`DCRB_BIT_FWD];
      reverse_run_ff <= link_ok && run_command_word_ff[`DCRB_BIT_REV];
      step_select_ff <= nxt_step;
      ramp_set_sel_ff <= nxt_ramp;
      coast_stop_ff <= nxt_coast;
      rst_cnt_ff <= nxt_rst_cnt;
      fault_reset_ff <= (nxt_rst_cnt != 20'h00000);
      link_valid_ff <= link_ok;
    end
  end

endmodule

/* File: rtl/dcrb_defines.vh */
// Purpose: constants for the drive command register bank
// Assumes: 10 MHz core clock
// Notes: word indices select a command word on the link access port
`ifndef DCRB_DEFINES_VH
`define DCRB_DEFINES_VH

`define DCRB_CLK_KHZ 10000
`define DCRB_RST_PULSE_US 1000
`define DCRB_RST_PULSE_CYC (`DCRB_RST_PULSE_US * `DCRB_CLK_KHZ / 1000)

`define DCRB_IDX_W 3
`define DCRB_IDX_PU 3'h0
`define DCRB_IDX_CHZ 3'h1
`define DCRB_IDX_PID 3'h2
`define DCRB_IDX_RPM 3'h3
`define DCRB_IDX_RUN 3'h4
`define DCRB_IDX_CLR 3'h5

`define DCRB_BIT_FWD 0
`define DCRB_BIT_REV 1
`define DCRB_BIT_GP0 2
`define DCRB_BIT_RST 15

`define DCRB_WORD_RST 16'h0000
`define DCRB_PU_FULL 16'h4E20
`define DCRB_CLR_ONE 16'h0001

`define DCRB_ASG_SS1 8'h00
`define DCRB_ASG_SS2 8'h01
`define DCRB_ASG_SS4 8'h02
`define DCRB_ASG_SS8 8'h03
`define DCRB_ASG_RT1 8'h04
`define DCRB_ASG_RT2 8'h05
`define DCRB_ASG_BX 8'h07

`define DCRB_SRC_NONE 2'h0
`define DCRB_SRC_PU 2'h1
`define DCRB_SRC_CHZ 2'h2
`define DCRB_SRC_RPM 2'h3

`endif

/* File: verification/dcrb_chk.sv */
// Purpose: port assertions for the command bank
// Assumes: short reset pulse count in simulation
// Notes: pulse length is a floor, a rewrite stretches it
`timescale 1ns/100ps
module dcrb_chk #(
  parameter [19:0] RST_PULSE_CYC = 20'h00008
) (
  // clock, reset and link port
  input wire core_clk,
  input wire arst_n,
  input wire wr_en,
  input wire rd_en,
  input wire [2:0] word_idx,
  input wire [15:0] wr_data,
  input wire [15:0] rd_data_ff,
  input wire rd_valid_ff,
  // source control
  input wire link_source_select,
  input wire link_enable_assigned,
  input wire link_enable_input,
  // commands
  input wire [1:0] freq_src_ff,
  input wire [15:0] freq_ref_ff,
  input wire forward_run_ff,
  input wire reverse_run_ff,
  input wire fault_reset_ff,
  input wire link_valid_ff
);
  reg [7:0] hi_cnt_ff;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n)
      hi_cnt_ff <= 8'h00;
    else
      hi_cnt_ff <= fault_reset_ff ? hi_cnt_ff + 8'h01 : 8'h00;
  end
  chk_rd_answer: assert property (rd_en |=> rd_valid_ff)
    else $error("read not answered");
  chk_rd_quiet: assert property (!rd_en |=> !rd_valid_ff && $stable(rd_data_ff))
    else $error("read data moved without a read");
  chk_clr_reads_zero: assert property (rd_en && word_idx >= 3'h5 |=> rd_data_ff == 16'h0000)
    else $error("clear or unmapped word read nonzero");
  chk_clr_pulse: assert property (wr_en && word_idx == 3'h5 && wr_data == 16'h0001 |-> ##[1:2] fault_reset_ff)
    else $error("clear write gave no reset");
  chk_pulse_len: assert property ($fell(fault_reset_ff) |-> hi_cnt_ff >= RST_PULSE_CYC)
    else $error("reset pulse too short");
  chk_pu_clamp: assert property (freq_src_ff == 2'h1 |-> $signed(freq_ref_ff) <= 20000 && $signed(freq_ref_ff) >= -20000)
    else $error("per-unit reference not clamped");
  chk_run_gated: assert property (!link_valid_ff [*2] |-> !forward_run_ff && !reverse_run_ff)
    else $error("run command without valid link");
  chk_sel_invalid: assert property (!link_source_select [*2] |-> !link_valid_ff)
    else $error("link valid without source select");
  chk_pin_invalid: assert property ((link_enable_assigned && !link_enable_input) [*4] |-> !link_valid_ff)
    else $error("link valid with enable pin low");
  cover property (fault_reset_ff ##1 !fault_reset_ff);
  cover property (freq_src_ff == 2'h3);
  cover property (rd_en && word_idx == 3'h7);
endmodule

bind dcrb_cmd_bank dcrb_chk #(.RST_PULSE_CYC(RST_PULSE_CYC)) u_dcrb_chk (
  .core_clk, .arst_n, .wr_en, .rd_en, .word_idx, .wr_data, .rd_data_ff,
  .rd_valid_ff, .link_source_select, .link_enable_assigned,
  .link_enable_input, .freq_src_ff, .freq_ref_ff, .forward_run_ff,
  .reverse_run_ff, .fault_reset_ff, .link_valid_ff);

/* File: verification/dcrb_host.sv */
// Purpose: host controller on the command link
// Assumes: strobes launched at the rising edge
// Notes: idle data shows the inverse of the last word
`timescale 1ns/100ps
module dcrb_host (
  // clock and answer
  input wire core_clk,
  input wire rd_valid_ff,
  input wire [15:0] rd_data_ff,
  // requests
  output reg wr_en,
  output reg rd_en,
  output reg [2:0] word_idx,
  output reg [15:0] wr_data
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    word_idx = 3'h0;
    wr_data = 16'h0000;
  end
  task wr(input [2:0] i, input [15:0] d);
    begin
      @(posedge core_clk);
      wr_en <= 1'b1;
      word_idx <= i;
      wr_data <= d;
      @(posedge core_clk);
      wr_en <= 1'b0;
      wr_data <= ~d;
    end
  endtask
  task rd(input [2:0] i, output [15:0] d, output ok);
    integer n;
    begin
      @(posedge core_clk);
      rd_en <= 1'b1;
      word_idx <= i;
      @(posedge core_clk);
      rd_en <= 1'b0;
      ok = 1'b0;
      for (n = 0; n < 4 && !ok; n = n + 1) begin
        @(posedge core_clk);
        ok = rd_valid_ff === 1'b1;
        d = rd_data_ff;
      end
    end
  endtask
  // run bits stay clear so the drive cannot start on reset
  task alarm_by_run;
    begin
      wr(3'h4, 16'h8000);
      wr(3'h4, 16'h0000);
    end
  endtask
endmodule

/* File: verification/drive_command_register_bank_tb_top.sv */
// Purpose: self-checking bench for the command bank
// Assumes: reset pulse shortened to 8 cycles
// Notes: pulse lengths are counted by a sampling process
`timescale 1ns/100ps
module drive_command_register_bank_tb_top;
  reg core_clk, arst_n, link_source_select, bus_source_select;
  reg loader_source_select, link_enable_assigned, link_enable_input;
  reg [87:0] terminal_assign_setting;
  reg [15:0] upper_limit_pu, pulse_n;
  wire wr_en, rd_en, rd_valid_ff, forward_run_ff, reverse_run_ff;
  wire coast_stop_ff, fault_reset_ff, link_valid_ff;
  wire [2:0] word_idx;
  wire [1:0] freq_src_ff, ramp_set_sel_ff;
  wire [3:0] step_select_ff;
  wire [15:0] wr_data, rd_data_ff, freq_ref_ff, pid_setpoint_ff, speed_ff;
  integer mismatches, check_count;
  dcrb_host u_dcrb_host (.core_clk, .rd_valid_ff, .rd_data_ff, .wr_en,
    .rd_en, .word_idx, .wr_data);
  dcrb_cmd_bank #(.PID_NEG_ZERO(1), .RST_PULSE_CYC(20'h00008))
    u_dcrb_cmd_bank (.core_clk, .arst_n, .wr_en, .rd_en, .word_idx,
    .wr_data, .rd_data_ff, .rd_valid_ff, .link_source_select,
    .bus_source_select, .loader_source_select, .link_enable_assigned,
    .link_enable_input, .terminal_assign_setting, .upper_limit_pu,
    .freq_src_ff, .freq_ref_ff, .pid_setpoint_ff, .speed_ff,
    .forward_run_ff, .reverse_run_ff, .step_select_ff, .ramp_set_sel_ff,
    .coast_stop_ff, .fault_reset_ff, .link_valid_ff);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (fault_reset_ff === 1'b1) pulse_n <= pulse_n + 16'h0001;
  task check(input string nm, input [15:0] s, input [15:0] e);
    begin
      check_count = check_count + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("ERROR %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task st;
    begin
      repeat (2) @(posedge core_clk);
      #1;
    end
  endtask
  task w(input [2:0] i, input [15:0] d);
    begin
      u_dcrb_host.wr(i, d);
      st;
    end
  endtask
  task rc(input [2:0] i, input [15:0] e);
    reg [15:0] d;
    reg ok;
    begin
      u_dcrb_host.rd(i, d, ok);
      if (!ok) begin
        mismatches = mismatches + 1;
        summarize;
      end
      check("read word", d, e);
    end
  endtask
  task wf(input [2:0] i, input [15:0] d, input [1:0] s, input [15:0] r);
    begin
      w(i, d);
      check("freq src", freq_src_ff, s);
      check("freq ref", freq_ref_ff, r);
    end
  endtask
  // waits out the longest pulse, a rewrite included
  task pc(input [15:0] e);
    begin
      repeat (16) @(posedge core_clk);
      #1;
      check("reset pulse", pulse_n, e);
      pulse_n = 16'h0000;
    end
  endtask
  task t_reset;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1)
        rc(i[2:0], 16'h0000);
      w(3'h7, 16'hFFFF);
      rc(3'h7, 16'h0000);
      $display("t_reset done");
    end
  endtask
  task t_prec;
    begin
      wf(3'h1, 16'h04D2, 2'h2, 16'h04D2);
      wf(3'h3, 16'hFFFB, 2'h2, 16'h04D2);
      wf(3'h0, 16'h2710, 2'h1, 16'h2710);
      wf(3'h0, 16'h0000, 2'h2, 16'h04D2);
      wf(3'h1, 16'h0000, 2'h3, 16'hFFFB);
      rc(3'h3, 16'hFFFB);
      $display("t_prec done");
    end
  endtask
  task t_scale;
    begin
      wf(3'h0, 16'h61A8, 2'h1, 16'h4E20);
      rc(3'h0, 16'h61A8);
      @(posedge core_clk) upper_limit_pu <= 16'h3A98;
      wf(3'h0, 16'h9E58, 2'h1, 16'hC568);
      w(3'h2, 16'h8000);
      check("pid", pid_setpoint_ff, 16'h0000);
      rc(3'h2, 16'h8000);
      w(3'h2, 16'h4E20);
      check("pid", pid_setpoint_ff, 16'h4E20);
      $display("t_scale done");
    end
  endtask
  task t_run;
    begin
      w(3'h4, 16'h01FF);
      check("run", {forward_run_ff, reverse_run_ff, step_select_ff, ramp_set_sel_ff, coast_stop_ff}, 16'h01FF);
      w(3'h4, 16'h0014);
      check("run", {forward_run_ff, reverse_run_ff, step_select_ff, ramp_set_sel_ff, coast_stop_ff}, 16'h0028);
      w(3'h4, 16'h0160);
      check("run", {forward_run_ff, reverse_run_ff, step_select_ff, ramp_set_sel_ff, coast_stop_ff}, 16'h0043);
      w(3'h4, 16'h7E00);
      check("run", {forward_run_ff, reverse_run_ff, step_select_ff, ramp_set_sel_ff, coast_stop_ff}, 16'h0000);
      @(posedge core_clk) link_source_select <= 1'b0;
      w(3'h4, 16'h0003);
      check("fwd gated", forward_run_ff, 16'h0000);
      @(posedge core_clk) link_source_select <= 1'b1;
      link_enable_assigned <= 1'b1;
      w(3'h4, 16'h0000);
      check("link valid", link_valid_ff, 16'h0000);
      @(posedge core_clk) link_enable_input <= 1'b1;
      repeat (2) st;
      check("link valid", link_valid_ff, 16'h0001);
      $display("t_run done");
    end
  endtask
  task t_alarm;
    begin
      pulse_n = 16'h0000;
      u_dcrb_host.alarm_by_run;
      pc(16'h0008);
      @(posedge core_clk) link_enable_input <= 1'b0;
      u_dcrb_host.alarm_by_run;
      pc(16'h0000);
      u_dcrb_host.wr(3'h5, 16'h0001);
      pc(16'h0008);
      u_dcrb_host.wr(3'h5, 16'h0002);
      pc(16'h0000);
      rc(3'h5, 16'h0000);
      u_dcrb_host.wr(3'h5, 16'h0001);
      repeat (3) @(posedge core_clk);
      u_dcrb_host.wr(3'h5, 16'h0001);
      pc(16'h000D);
      $display("t_alarm done");
    end
  endtask
  initial begin
    arst_n = 1'b0;
    link_source_select = 1'b1;
    bus_source_select = 1'b1;
    loader_source_select = 1'b1;
    link_enable_assigned = 1'b0;
    link_enable_input = 1'b0;
    terminal_assign_setting = 88'hFFFFFFFF07050403020100;
    upper_limit_pu = 16'hFFFF;
    pulse_n = 16'h0000;
    mismatches = 0;
    check_count = 0;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset;
    t_prec;
    t_scale;
    t_run;
    t_alarm;
    summarize;
  end
endmodule
